// *** include/prh_cmd_if.sv ***
// Interface: command channel from register block to sequencer
`timescale 1ns/1ps
interface prh_cmd_if;
    logic start;
    logic [2:0] cmd;
    logic [15:0] pulse_cyc;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic busy;
    logic done;
    logic [7:0] rdata;
    modport regs (output start, cmd, pulse_cyc, addr, wdata,
                  input busy, done, rdata);
    modport seq (input start, cmd, pulse_cyc, addr, wdata,
                 output busy, done, rdata);
endinterface : prh_cmd_if

// *** include/prh_pkg.sv ***
// Package: constants and types for the paged ROM host controller
package prh_pkg;
    // Clock
    localparam int CLK_MHZ = 25;
    localparam int CLK_NS = 40;
    // Times in ns
    localparam int ACCESS_NS = 170;
    localparam int GATE_NS = 65;
    localparam int SEL_TO_STROBE_END_NS = 100;
    localparam int STROBE_WIDTH_NS = 50;
    localparam int WRITE_RECOVERY_NS = 20;
    localparam int GATE_HIGH_TO_STROBE_NS = 55;
    localparam int RESET_LOW_NS = 100;
    localparam int RESET_TO_ADDR_NS = 150;
    // Cycle counts, least times rounded up
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc
    localparam int ACCESS_CYC = ns_to_cyc(ACCESS_NS);
    localparam int GATE_CYC = ns_to_cyc(GATE_NS);
    localparam int SEL_STROBE_CYC = ns_to_cyc(SEL_TO_STROBE_END_NS);
    localparam int STROBE_CYC = ns_to_cyc(STROBE_WIDTH_NS);
    localparam int RECOVERY_CYC = ns_to_cyc(WRITE_RECOVERY_NS);
    localparam int GATE_STROBE_CYC = ns_to_cyc(GATE_HIGH_TO_STROBE_NS);
    localparam int RESET_LOW_CYC = ns_to_cyc(RESET_LOW_NS);
    localparam int RESET_ADDR_CYC = ns_to_cyc(RESET_TO_ADDR_NS);
    // Geometry
    localparam int IN_PAGE_BITS = 14;
    localparam int PAGE_BITS = 2;
    localparam int DATA_BITS = 8;
    localparam int SIG_HV_BIT = 9;
    // Register offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_ADDR = 12'h004;
    localparam logic [11:0] OFS_WDATA = 12'h008;
    localparam logic [11:0] OFS_RDATA = 12'h00c;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    // Command codes in CTRL[2:0]; writing CTRL while not busy starts it
    typedef enum logic [2:0] {
        PRH_CMD_READ = 3'h0,
        PRH_CMD_PAGE = 3'h1,
        PRH_CMD_RESET = 3'h2,
        PRH_CMD_SIG = 3'h3,
        PRH_CMD_PROG = 3'h4,
        PRH_CMD_INHIBIT = 3'h5
    } prh_cmd_e;
    localparam int CTRL_PULSE_LSB = 8;
    localparam int CTRL_PULSE_W = 16;
    localparam logic [15:0] PULSE_RESET = 16'h0019;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_ERR = 2;
endpackage : prh_pkg

// *** logic/prh_ctrl.sv ***
// Top: host controller driving a paged ROM through its pins
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// How it works
// - Select picks the device and stays low across the whole cycle, except an inhibit or reset cycle, which keeps it high.
// - Select and gate together time when read data is driven onto the bus.
// - Gate falls one cycle after select, well inside the allowed lag.
// - Write strobe stays high through every read.
// - Gate stays high for the whole page write cycle.
// - Select low 100 ns and strobe low 50 ns before ending write.
// - Strobe falls at least 55 ns after gate went high.
// - At least 20 ns recovery follows every page write.
// - Reset pin held low at least 100 ns; page returns to zero.
// - No address access until 150 ns after reset release.
module prh_ctrl #(
    parameter bit HAS_PAGE_RESET = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // ROM control pins
    output logic rom_select_n,
    output logic rom_gate_n,
    output logic rom_prog_hv,
    output logic rom_strobe_n,
    output logic rom_reset_n,
    output logic signature_hv_addr_bit,
    output logic [prh_pkg::IN_PAGE_BITS-1:0] rom_addr,
    // ROM data pins
    input wire logic [prh_pkg::DATA_BITS-1:0] rom_data_in,
    output logic [prh_pkg::DATA_BITS-1:0] rom_data_out,
    output logic rom_data_oe,
    // Mirror of the page latch
    output logic [prh_pkg::PAGE_BITS-1:0] page_now
);
    import prh_pkg::*;
    typedef enum {
        ST_IDLE, ST_SETUP, ST_GATE, ST_STROBE, ST_HOLD, ST_RECOVER,
        ST_RST_LOW, ST_RST_WAIT, ST_PROG
    } prh_state_e;
    localparam int CW = 16;
    localparam logic [CW-1:0] C_ACCESS = CW'(ACCESS_CYC);
    localparam logic [CW-1:0] C_GATE = CW'(GATE_CYC);
    localparam logic [CW-1:0] C_SELSTB = CW'(SEL_STROBE_CYC);
    localparam logic [CW-1:0] C_STROBE = CW'(STROBE_CYC);
    localparam logic [CW-1:0] C_RECOV = CW'(RECOVERY_CYC);
    localparam logic [CW-1:0] C_GSTB = CW'(GATE_STROBE_CYC);
    localparam logic [CW-1:0] C_RLOW = CW'(RESET_LOW_CYC);
    localparam logic [CW-1:0] C_RADDR = CW'(RESET_ADDR_CYC);
    // Reads need the access count to outlast the gate count
    if (ACCESS_CYC < GATE_CYC + 1) begin : g_bad_counts
        $error("access count shorter than gate count");
    end
    prh_cmd_if cmd_bus ();
    prh_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cmd_port(cmd_bus.regs)
    );
    prh_state_e state;
    logic [CW-1:0] cnt;
    logic [2:0] op;
    logic [CW-1:0] wait_after;
    logic [7:0] rdata;
    // Max of two counts
    function automatic logic [CW-1:0] cmax(input logic [CW-1:0] a,
                                           input logic [CW-1:0] b);
        return (a > b) ? a : b;
    endfunction : cmax
    assign cmd_bus.busy = state != ST_IDLE;
    assign cmd_bus.rdata = rdata;
    // --------------------------------
    // Sequencer
    // --------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            cnt <= '0;
            op <= 3'h0;
            wait_after <= '0;
            cmd_bus.done <= 1'b0;
        end else begin
            cmd_bus.done <= 1'b0;
            if (cnt != '0) begin
                cnt <= cnt - 1'b1;
            end
            unique case (state)
                ST_IDLE: begin
                    if (cmd_bus.start) begin
                        op <= cmd_bus.cmd;
                        cnt <= '0;
                        if (cmd_bus.cmd == PRH_CMD_RESET) begin
                            state <= ST_RST_LOW;
                            cnt <= C_RLOW - 1'b1;
                        end else begin
                            state <= ST_SETUP;
                        end
                    end
                end
                ST_SETUP: begin
                    // Select settles one cycle before gate or strobe
                    if (op == PRH_CMD_PAGE) begin
                        state <= ST_STROBE;
                        cnt <= cmax(C_SELSTB, C_STROBE) - 1'b1;
                    end else if (op == PRH_CMD_PROG ||
                                 op == PRH_CMD_INHIBIT) begin
                        state <= ST_PROG;
                        cnt <= cmd_bus.pulse_cyc;
                    end else begin
                        state <= ST_GATE;
                        cnt <= cmax(C_ACCESS - 1'b1, C_GATE);
                    end
                end
                ST_GATE: begin
                    if (cnt == '0) begin
                        state <= ST_HOLD;
                    end
                end
                ST_STROBE: begin
                    if (cnt == '0) begin
                        state <= ST_HOLD;
                    end
                end
                ST_PROG: begin
                    if (cnt == '0) begin
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    state <= ST_RECOVER;
                    cnt <= C_RECOV - 1'b1;
                end
                ST_RECOVER: begin
                    if (cnt == '0) begin
                        state <= ST_IDLE;
                        cmd_bus.done <= 1'b1;
                    end
                end
                ST_RST_LOW: begin
                    if (cnt == '0) begin
                        state <= ST_RST_WAIT;
                        cnt <= C_RADDR - 1'b1;
                    end
                end
                ST_RST_WAIT: begin
                    if (cnt == '0) begin
                        state <= ST_IDLE;
                        cmd_bus.done <= 1'b1;
                    end
                end
            endcase
        end
    end
    // --------------------------------
    // Pin drive
    // --------------------------------
    logic is_read;
    assign is_read = op == PRH_CMD_READ || op == PRH_CMD_SIG;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_select_n <= 1'b1;
            rom_gate_n <= 1'b1;
            rom_prog_hv <= 1'b0;
            rom_strobe_n <= 1'b1;
            rom_reset_n <= 1'b1;
            signature_hv_addr_bit <= 1'b0;
            rom_addr <= '0;
            rom_data_out <= 8'hff;
            rom_data_oe <= 1'b0;
        end else begin
            rom_reset_n <= !(HAS_PAGE_RESET &&
                (state == ST_RST_LOW || (state == ST_IDLE &&
                 cmd_bus.start && cmd_bus.cmd == PRH_CMD_RESET)));
            if (state == ST_IDLE && cmd_bus.start &&
                cmd_bus.cmd != PRH_CMD_RESET) begin
                // Inhibit keeps select high under programming voltage
                rom_select_n <= cmd_bus.cmd == PRH_CMD_INHIBIT;
                if (cmd_bus.cmd == PRH_CMD_SIG) begin
                    rom_addr <= {13'h0, cmd_bus.addr[0]};
                    signature_hv_addr_bit <= 1'b1;
                end else begin
                    rom_addr <= cmd_bus.addr[IN_PAGE_BITS-1:0];
                end
                if (cmd_bus.cmd == PRH_CMD_PAGE) begin
                    rom_data_out <= {6'h00,
                        cmd_bus.wdata[PAGE_BITS-1:0]};
                    rom_data_oe <= 1'b1;
                end else if (cmd_bus.cmd == PRH_CMD_PROG ||
                             cmd_bus.cmd == PRH_CMD_INHIBIT) begin
                    rom_data_out <= cmd_bus.wdata;
                    rom_data_oe <= 1'b1;
                end
            end
            if (state == ST_SETUP) begin
                rom_gate_n <= !is_read;
                rom_strobe_n <= op != PRH_CMD_PAGE;
                rom_prog_hv <= op == PRH_CMD_PROG || op == PRH_CMD_INHIBIT;
            end
            if (state == ST_HOLD) begin
                rom_strobe_n <= 1'b1;
                rom_gate_n <= 1'b1;
                rom_prog_hv <= 1'b0;
                rom_select_n <= 1'b1;
                signature_hv_addr_bit <= 1'b0;
            end
            if (state == ST_RECOVER && cnt == '0) begin
                rom_data_oe <= 1'b0;
            end
        end
    end
    // --------------------------------
    // Read capture and page mirror
    // --------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 8'h00;
            page_now <= '0;
        end else begin
            if (state == ST_GATE && cnt == '0) begin
                rdata <= rom_data_in;
            end
            if (state == ST_HOLD && op == PRH_CMD_PAGE) begin
                page_now <= rom_data_out[PAGE_BITS-1:0];
            end
            if (state == ST_RST_LOW && HAS_PAGE_RESET) begin
                page_now <= '0;
            end
        end
    end
    // --------------------------------
    // Assertions
    // --------------------------------
    property p_strobe_read;
        @(posedge pclk) disable iff (!presetn)
        !rom_gate_n |-> rom_strobe_n;
    endproperty
    a_strobe_read: assert property (p_strobe_read)
        else $error("strobe low while gate low");
    property p_gate_write;
        @(posedge pclk) disable iff (!presetn)
        !rom_strobe_n |-> rom_gate_n && !rom_select_n && rom_reset_n;
    endproperty
    a_gate_write: assert property (p_gate_write)
        else $error("bad pins during page write");
    property p_strobe_width;
        @(posedge pclk) disable iff (!presetn)
        $fell(rom_strobe_n) |-> !rom_strobe_n [*3];
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("page write strobe too short");
    property p_gate_to_strobe;
        @(posedge pclk) disable iff (!presetn)
        $fell(rom_strobe_n) |-> rom_gate_n && $past(rom_gate_n) &&
            $past(rom_gate_n, 2);
    endproperty
    a_gate_to_strobe: assert property (p_gate_to_strobe)
        else $error("strobe fell too soon after gate");
    property p_recovery;
        @(posedge pclk) disable iff (!presetn)
        $rose(rom_strobe_n) |-> rom_select_n [*2];
    endproperty
    a_recovery: assert property (p_recovery)
        else $error("no recovery after page write");
    property p_sel_before_end;
        @(posedge pclk) disable iff (!presetn)
        $rose(rom_strobe_n) |-> !$past(rom_select_n, 1) &&
            !$past(rom_select_n, 2) && !$past(rom_select_n, 3);
    endproperty
    a_sel_before_end: assert property (p_sel_before_end)
        else $error("select not low long enough before write end");
    property p_reset_len;
        @(posedge pclk) disable iff (!presetn)
        $fell(rom_reset_n) |-> !rom_reset_n [*3];
    endproperty
    a_reset_len: assert property (p_reset_len)
        else $error("reset pulse too short");
    property p_reset_gap;
        @(posedge pclk) disable iff (!presetn)
        $rose(rom_reset_n) |-> rom_select_n [*4];
    endproperty
    a_reset_gap: assert property (p_reset_gap)
        else $error("access too soon after reset");
    property p_sample_late;
        @(posedge pclk) disable iff (!presetn)
        $fell(rom_gate_n) |-> !rom_gate_n [*2] ##1 !rom_select_n;
    endproperty
    a_sample_late: assert property (p_sample_late)
        else $error("read cycle ended too early");
    property p_sig_addr;
        @(posedge pclk) disable iff (!presetn)
        signature_hv_addr_bit |-> rom_addr[IN_PAGE_BITS-1:1] == '0;
    endproperty
    a_sig_addr: assert property (p_sig_addr)
        else $error("address bits set in signature mode");
    property p_no_reset_pin;
        @(posedge pclk) disable iff (!presetn)
        !rom_reset_n |-> HAS_PAGE_RESET &&
            (state == ST_RST_LOW || state == ST_RST_WAIT);
    endproperty
    a_no_reset_pin: assert property (p_no_reset_pin)
        else $error("reset pin driven without the option");
    c_read: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(rom_gate_n) && !signature_hv_addr_bit);
    c_page: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(rom_strobe_n));
    c_reset: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(rom_reset_n));
    c_sig: cover property (@(posedge pclk) disable iff (!presetn)
        signature_hv_addr_bit && !rom_gate_n);
    c_prog: cover property (@(posedge pclk) disable iff (!presetn)
        rom_prog_hv && !rom_select_n);
endmodule : prh_ctrl

// *** logic/prh_regs.sv ***
// APB register block of the paged ROM host controller
`timescale 1ns/1ps
module prh_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer
    prh_cmd_if.regs cmd_port
);
    import prh_pkg::*;
    logic [2:0] cmd;
    logic [15:0] pulse;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic done_flag;
    logic start;
    logic err;
    logic wr_en;
    logic mapped;
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign mapped = paddr == OFS_CTRL || paddr == OFS_ADDR ||
        paddr == OFS_WDATA || paddr == OFS_RDATA || paddr == OFS_STATUS;
    assign pslverr = psel & penable & ~mapped;
    assign cmd_port.start = start;
    assign cmd_port.cmd = cmd;
    assign cmd_port.pulse_cyc = pulse;
    assign cmd_port.addr = addr;
    assign cmd_port.wdata = wdata;
    // --------------------------------
    // Writable registers
    // --------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= 3'h0;
            pulse <= PULSE_RESET;
            addr <= 16'h0000;
            wdata <= 8'hff;
            start <= 1'b0;
        end else begin
            start <= 1'b0;
            if (wr_en && paddr == OFS_CTRL && !cmd_port.busy) begin
                cmd <= pwdata[2:0];
                pulse <= pwdata[CTRL_PULSE_LSB +: CTRL_PULSE_W];
                start <= 1'b1;
            end
            if (wr_en && paddr == OFS_ADDR) begin
                addr <= pwdata[15:0];
            end
            if (wr_en && paddr == OFS_WDATA) begin
                wdata <= pwdata[7:0];
            end
        end
    end
    // --------------------------------
    // Sticky status; set wins over clear
    // --------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
            err <= 1'b0;
        end else begin
            if (cmd_port.done) begin
                done_flag <= 1'b1;
            end else if (wr_en && paddr == OFS_STATUS &&
                         pwdata[STAT_DONE]) begin
                done_flag <= 1'b0;
            end
            if (wr_en && paddr == OFS_CTRL && cmd_port.busy) begin
                err <= 1'b1;
            end else if (wr_en && paddr == OFS_STATUS &&
                         pwdata[STAT_ERR]) begin
                err <= 1'b0;
            end
        end
    end
    // --------------------------------
    // Read mux
    // --------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: prdata = {8'h00, pulse, 5'h00, cmd};
            OFS_ADDR: prdata = {16'h0000, addr};
            OFS_WDATA: prdata = {24'h000000, wdata};
            OFS_RDATA: prdata = {24'h000000, cmd_port.rdata};
            OFS_STATUS: prdata = {29'h0, err, done_flag,
                                  cmd_port.busy | start};
            default: prdata = 32'h0000_0000;
        endcase
    end
endmodule : prh_regs

// *** test/prh_ctrl_tb_top.sv ***
// Self-checking bench of the paged ROM host controller
`timescale 1ns/1ps
module prh_ctrl_tb_top;
    import prh_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, st;
    logic pready, pslverr, se, sel_n, gate_n, hv, stb_n, rst_n, sig_hv, oe;
    logic [13:0] raddr;
    logic [7:0] dout, din, ddev, flt = 8'h00;
    logic doe;
    logic [1:0] page_now;
    int viol, err_total = 0, checks_done = 0;
    always #20 pclk = ~pclk;
    // Wire level: host, then device, else a changing float
    assign din = oe ? dout : (doe ? ddev : flt);
    always @(posedge pclk) flt <= ~din;
    prh_ctrl #(.HAS_PAGE_RESET(1'b1)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rom_select_n(sel_n), .rom_gate_n(gate_n),
        .rom_prog_hv(hv), .rom_strobe_n(stb_n), .rom_reset_n(rst_n),
        .signature_hv_addr_bit(sig_hv), .rom_addr(raddr),
        .rom_data_in(din), .rom_data_out(dout), .rom_data_oe(oe),
        .page_now(page_now));
    prh_rom_model #(.HAS_PAGE_RESET(1'b1)) dev (.select_n(sel_n),
        .gate_n(gate_n), .prog_hv(hv), .strobe_n(stb_n), .reset_n(rst_n),
        .sig_hv(sig_hv), .addr(raddr), .bus(din), .host_oe(oe),
        .dev_data(ddev), .dev_oe(doe), .viol(viol));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ {a[15:14], a[13:8]};
    endfunction : pat
    task automatic close_out;
        if (err_total == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk({31'h0, pready}, 32'h1);
            close_out();
        end
    endtask : apb
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rd[STAT_DONE] !== 1'b1 && n < 100);
        st = rd;
        if (rd[STAT_DONE] !== 1'b1) begin
            chk({31'h0, rd[STAT_DONE]}, 32'h1);
            close_out();
        end else begin
            apb(1'b1, OFS_STATUS, 32'h6);
        end
    endtask : wait_done
    task automatic run(input logic [2:0] c, input logic [15:0] a,
                       input logic [7:0] d);
        apb(1'b1, OFS_ADDR, {16'h0, a});
        apb(1'b1, OFS_WDATA, {24'h0, d});
        apb(1'b1, OFS_CTRL, {8'h0, 16'h0004, 5'h0, c});
        wait_done();
        chk({29'h0, st[2:0]}, 32'h2);
    endtask : run
    task automatic rd_byte(input logic [15:0] a, input logic [7:0] exp);
        run(PRH_CMD_READ, a, 8'h00);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk(rd, {24'h0, exp});
    endtask : rd_byte
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_idle;
        chk({25'h0, sel_n, gate_n, stb_n, rst_n, hv, sig_hv, oe}, 32'h78);
        chk({30'h0, page_now}, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        rd_byte(16'h1234, pat(16'h1234));
    endtask : t_idle
    task automatic t_pages;
        for (int i = 0; i < 4; i++) begin
            run(PRH_CMD_PAGE, 16'h2aaa, 8'(i));
            chk({30'h0, page_now}, 32'(i));
            chk({30'h0, dev.page}, 32'(i));
            rd_byte(16'h3fff, pat({2'(i), 14'h3fff}));
        end
        run(PRH_CMD_RESET, 16'h0, 8'h0);
        chk({30'h0, page_now}, 32'h0);
        chk({30'h0, dev.page}, 32'h0);
    endtask : t_pages
    task automatic t_sig;
        run(PRH_CMD_SIG, 16'h0000, 8'h0);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk(rd, {24'h0, dev.MAKER_CODE});
        run(PRH_CMD_SIG, 16'h0001, 8'h0);
        apb(1'b0, OFS_RDATA, 32'h0);
        chk(rd, {24'h0, dev.PART_CODE});
    endtask : t_sig
    task automatic t_prog;
        run(PRH_CMD_PROG, 16'h01f3, 8'h3c);
        rd_byte(16'h01f3, pat(16'h01f3) & 8'h3c);
        run(PRH_CMD_INHIBIT, 16'h02f3, 8'h00);
        rd_byte(16'h02f3, pat(16'h02f3));
    endtask : t_prog
    task automatic t_refuse;
        apb(1'b1, OFS_CTRL, {29'h0, PRH_CMD_READ});
        apb(1'b1, OFS_CTRL, {29'h0, PRH_CMD_READ});
        wait_done();
        chk({29'h0, st[2:0]}, 32'h6);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, se}, 32'h1);
        chk(rd, 32'h0);
    endtask : t_refuse
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_idle();
        t_pages();
        t_sig();
        t_prog();
        t_refuse();
        chk(32'(viol), 32'h0);
        close_out();
    end
endmodule : prh_ctrl_tb_top

// *** test/prh_rom_model.sv ***
// Behavioural model of the paged ROM facing the host controller
`timescale 1ns/1ps
module prh_rom_model #(
    parameter bit HAS_PAGE_RESET = 1'b1,
    parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'h5a // Arbitrary value
) (
    // Control pins
    input wire logic select_n,
    input wire logic gate_n,
    input wire logic prog_hv,
    input wire logic strobe_n,
    input wire logic reset_n,
    input wire logic sig_hv,
    input wire logic [13:0] addr,
    // Data pins
    input wire logic [7:0] bus,
    input wire logic host_oe,
    output logic [7:0] dev_data,
    output logic dev_oe,
    // Count of timing faults and bus contention seen
    output int viol
);
    import prh_pkg::*;
    logic [1:0] page = 2'h0;
    logic [7:0] burned [0:65535];
    logic [7:0] pend;
    logic pend_ok = 1'b0;
    logic rst_on;
    logic [15:0] full;
    realtime t_sel = -1e6, t_gate = -1e6, t_gh = -1e6, t_sf = -1e6;
    realtime t_self = -1e6, t_wend = -1e6, t_rf = -1e6, t_rr = -1e6;
    initial viol = 0;
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ {a[15:14], a[13:8]};
    endfunction : pat
    initial for (int i = 0; i < 65536; i++) burned[i] = pat(16'(i));
    assign rst_on = HAS_PAGE_RESET && !reset_n;
    assign full = {page, addr};
    // ------------------------------------------------------------
    // Read path, early data shows inverted
    // ------------------------------------------------------------
    always begin
        dev_oe = !select_n && !gate_n && !prog_hv && strobe_n && !rst_on;
        if (sig_hv && addr[13:1] == 13'h0)
            dev_data = addr[0] ? PART_CODE : MAKER_CODE;
        else
            dev_data = burned[full];
        if ($realtime - t_sel < ACCESS_NS || $realtime - t_gate < GATE_NS)
            dev_data = ~dev_data;
        if (dev_oe && host_oe)
            viol++;
        #1;
    end
    // ------------------------------------------------------------
    // Page latch and programming
    // ------------------------------------------------------------
    always @* begin
        if (rst_on)
            page = 2'h0;
        else if (!select_n && gate_n && !strobe_n && !prog_hv)
            page = bus[1:0];
    end
    always @* if (prog_hv && !select_n && host_oe) begin
        pend = bus;
        pend_ok = 1'b1;
    end
    always @(negedge prog_hv) begin
        if (pend_ok)
            burned[full] = pend & burned[full];
        pend_ok = 1'b0;
    end
    // ------------------------------------------------------------
    // Host timing watch
    // ------------------------------------------------------------
    always @(select_n, addr, sig_hv) t_sel = $realtime;
    always @(posedge gate_n) t_gh = $realtime;
    always @(negedge reset_n) t_rf = $realtime;
    always @(negedge gate_n) begin
        t_gate = $realtime;
        if (!strobe_n) viol++;
    end
    always @(negedge strobe_n) begin
        if (!gate_n || $realtime - t_gh < GATE_HIGH_TO_STROBE_NS)
            viol++;
        t_sf = $realtime;
    end
    always @(posedge strobe_n) begin
        if ($realtime - t_self < SEL_TO_STROBE_END_NS &&
            $realtime - t_sf < STROBE_WIDTH_NS) viol++;
        t_wend = $realtime;
    end
    always @(negedge select_n) begin
        if ($realtime - t_wend < WRITE_RECOVERY_NS ||
            $realtime - t_rr < RESET_TO_ADDR_NS) viol++;
        t_self = $realtime;
    end
    always @(posedge reset_n) begin
        if ($realtime - t_rf < RESET_LOW_NS) viol++;
        t_rr = $realtime;
    end
endmodule : prh_rom_model
